// ==== src/pfep_pkg.sv ====
package pfep_pkg;
  localparam int lanes = 2;
  localparam int dw = 16;
  localparam int aw = 16;
  localparam logic [7:0] cmd_erase = 8'h20;
  localparam logic [7:0] cmd_everify = 8'ha0;
  localparam logic [7:0] cmd_program = 8'h40;
  localparam logic [7:0] cmd_pverify = 8'hc0;
  localparam logic [7:0] cmd_reset = 8'hff;
  localparam logic [7:0] data_erased = 8'hff;
  localparam logic [7:0] data_zero = 8'h00;
  localparam logic [aw-1:0] addr_step = 16'h0002;
  localparam int clk_mhz = 20;
  localparam int t_erase_ms = 10;
  localparam int t_prog_us = 10;
  localparam int t_vsetup_us = 6;
  localparam int t_latency_cyc = 1;
  localparam logic [31:0] erase_cyc =
    32'(t_erase_ms * 1000 * clk_mhz);
  localparam logic [31:0] prog_cyc = 32'(t_prog_us * clk_mhz);
  localparam logic [31:0] vsetup_cyc = 32'(t_vsetup_us * clk_mhz);
  localparam logic [7:0] max_pulses = 8'h19;
  localparam logic [15:0] max_erase_pulses = 16'h03e8;
  typedef struct packed {
    logic we;
    logic oe;
    logic [aw-1:0] addr;
    logic [dw-1:0] wdata;
  } pfep_bus_type;
endpackage

// ==== src/pfep_timer.sv ====
`timescale 1ns/1ps
module pfep_timer (
  input wire logic mclk, // Clock
  input wire logic reset, // Async reset
  input wire logic load, // Load count and run
  input wire logic [31:0] count, // Cycles to run
  output logic done // Terminal count reached
);
  logic [15:0] pre_q;
  logic [15:0] main_q;
  logic run_q;
  // Low counter prescales the high one for a 32-bit span
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pre_q <= 16'h0000;
      main_q <= 16'h0000;
    end else if (load) begin
      pre_q <= count[15:0];
      main_q <= count[31:16];
    end else if (run_q) begin
      if (pre_q != 16'h0000) begin
        pre_q <= pre_q - 16'h0001;
      end else if (main_q != 16'h0000) begin
        pre_q <= 16'hffff;
        main_q <= main_q - 16'h0001;
      end
    end
  end
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      run_q <= 1'b0;
      done <= 1'b0;
    end else if (load) begin
      run_q <= 1'b1;
      done <= 1'b0;
    end else if (run_q && pre_q <= 16'h0001 && main_q == 16'h0000) begin
      run_q <= 1'b0;
      done <= 1'b1;
    end
  end
  a_done_sticky: assert property (@(posedge mclk) disable iff (reset)
    done && !load |=> done) else $error("timer done dropped");
endmodule // pfep_timer

// ==== src/pfep_seq.sv ====
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
// Summary of operation
// - After erase pulse, write word verify command.
// - Both lanes erased: address plus two, verify.
// - Neither erased: repeat erase, same address.
// - Each lane erased only when it reads FFh.
// - Verified lane gets reset code in commands.
// - All verified: restore commands, advance, verify.
// - Program pulse then verify, loop until match.
// - Program pulse ends at program-verify write.
// - Wait verify set-up before reading back.
// - Set-up wait is at least the minimum.
// - Program every location to zero before erase.
// - Keep word writes, neutral code in done lanes.
// - Byte mode steps address per device count; not built, word mode only.
// - Lane count scales from two to four; widths here are fixed at two lanes.
// - Timer loads count, sets done status bit.
// - Timer resolves one microsecond or finer.
// - Cascaded counters give 32-bit range.
// - Count includes interrupt response latency.
//////////////////////////////////////////////////////////////////////////
module pfep_seq (
  input wire logic mclk, // Clock, 20 MHz
  input wire logic reset, // Async reset, active high
  input wire logic start, // Pulse: begin operation
  input wire logic op_erase, // 1 erase (with pre-zero), 0 program
  input wire logic [15:0] last_addr, // Last word address
  input wire logic [15:0] prog_data, // Word to program at prog_addr
  output logic prog_req, // Wants next program word
  output logic [15:0] prog_addr, // Address of requested word
  output pfep_pkg::pfep_bus_type fbus, // Flash bus drive
  input wire logic [15:0] fdata_in, // Flash read data
  output logic busy, // Operation running
  output logic done, // Operation finished ok
  output logic [1:0] fail_lane // Lane that exceeded pulse limit
);
  typedef enum logic [3:0] {
    s_idle = 4'h0, s_pcmd = 4'h1, s_pdata = 4'h2, s_ppulse = 4'h3,
    s_pver = 4'h4, s_pset = 4'h5, s_pchk = 4'h6, s_ecmd1 = 4'h7,
    s_ecmd2 = 4'h8, s_epulse = 4'h9, s_ever = 4'ha, s_eset = 4'hb,
    s_echk = 4'hc, s_end = 4'hd
  } pfep_state_type;
  pfep_state_type state_q;
  logic [15:0] addr_q;
  logic [1:0] lane_ok_q;
  logic zero_pass_q;
  logic [7:0] ppulse_q;
  logic [15:0] epulse_q;
  logic tmr_load;
  logic [31:0] tmr_count;
  logic tmr_done;
  logic [15:0] want;
  logic [1:0] match;
  logic [15:0] cmd_word;
  logic [31:0] wait_q;
  //////////////////////////////////////////////////////////////////////
  pfep_timer u_timer (
    .mclk(mclk),
    .reset(reset),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );
  // Zero pass programs 00 everywhere, else caller data
  assign want = zero_pass_q ? {2{pfep_pkg::data_zero}} : prog_data;
  always_comb begin
    for (int i = 0; i < pfep_pkg::lanes; i++) begin
      if (state_q == s_echk)
        match[i] = fdata_in[8*i+:8] == pfep_pkg::data_erased;
      else
        match[i] = fdata_in[8*i+:8] == want[8*i+:8];
    end
  end
  // Lanes that already verified see the reset code, a no-op
  function automatic logic [15:0] mask_cmd(input logic [7:0] c,
                                           input logic [1:0] ok);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < pfep_pkg::lanes; i++) begin
      r[8*i+:8] = ok[i] ? pfep_pkg::cmd_reset : c;
    end
    return r;
  endfunction
  // Data to a finished lane is masked too: a data byte could decode as
  // a command in a device that already verified
  function automatic logic [15:0] mask_word(input logic [15:0] w,
                                            input logic [1:0] ok);
    logic [15:0] r;
    r = w;
    for (int i = 0; i < pfep_pkg::lanes; i++) begin
      if (ok[i]) r[8*i+:8] = pfep_pkg::cmd_reset;
    end
    return r;
  endfunction
  always_comb begin
    case (state_q)
      s_pcmd: cmd_word = mask_cmd(pfep_pkg::cmd_program, lane_ok_q);
      s_pdata: cmd_word = mask_word(want, lane_ok_q);
      s_pver: cmd_word = mask_cmd(pfep_pkg::cmd_pverify, lane_ok_q);
      s_ecmd1, s_ecmd2:
        cmd_word = mask_cmd(pfep_pkg::cmd_erase, lane_ok_q);
      s_ever: cmd_word = mask_cmd(pfep_pkg::cmd_everify, lane_ok_q);
      default: cmd_word = 16'h0000;
    endcase
  end
  always_comb begin
    tmr_load = 1'b0;
    tmr_count = 32'h0000_0000;
    case (state_q)
      s_pdata: begin
        tmr_load = 1'b1;
        // Subtract cycles spent reaching the verify write
        tmr_count = pfep_pkg::prog_cyc - pfep_pkg::t_latency_cyc;
      end
      s_ecmd2: begin
        tmr_load = 1'b1;
        tmr_count = pfep_pkg::erase_cyc - pfep_pkg::t_latency_cyc;
      end
      s_pver, s_ever: begin
        tmr_load = 1'b1;
        tmr_count = pfep_pkg::vsetup_cyc;
      end
      default: tmr_load = 1'b0;
    endcase
  end
  // Cycles spent in a program pulse or set-up wait; only the minimum-time
  // checks below read it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wait_q <= 32'h0000_0000;
    end else if (state_q inside {s_ppulse, s_pset, s_eset}) begin
      wait_q <= wait_q + 32'h0000_0001;
    end else begin
      wait_q <= 32'h0000_0000;
    end
  end
  // Registered so each write reaches the flash as one clean cycle,
  // at the cost of one cycle of lag behind the state
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fbus <= '0;
    end else begin
      fbus.we <= state_q inside {s_pcmd, s_pdata, s_pver, s_ecmd1,
                                 s_ecmd2, s_ever};
      fbus.oe <= state_q inside {s_pset, s_eset, s_pchk, s_echk};
      fbus.addr <= addr_q;
      fbus.wdata <= cmd_word;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= s_idle;
      addr_q <= 16'h0000;
      lane_ok_q <= 2'b00;
      zero_pass_q <= 1'b0;
      ppulse_q <= 8'h00;
      epulse_q <= 16'h0000;
      fail_lane <= 2'b00;
      done <= 1'b0;
    end else begin
      case (state_q)
        s_idle: begin
          if (start) begin
            addr_q <= 16'h0000;
            lane_ok_q <= 2'b00;
            ppulse_q <= 8'h00;
            epulse_q <= 16'h0000;
            fail_lane <= 2'b00;
            done <= 1'b0;
            zero_pass_q <= op_erase;
            state_q <= s_pcmd;
          end
        end
        s_pcmd: state_q <= s_pdata;
        s_pdata: begin
          ppulse_q <= ppulse_q + 8'h01;
          state_q <= s_ppulse;
        end
        s_ppulse: if (tmr_done) state_q <= s_pver;
        s_pver: state_q <= s_pset;
        s_pset: if (tmr_done) state_q <= s_pchk;
        s_pchk: begin
          if ((lane_ok_q | match) == 2'b11) begin
            lane_ok_q <= 2'b00;
            ppulse_q <= 8'h00;
            if (addr_q >= last_addr) begin
              addr_q <= 16'h0000;
              zero_pass_q <= 1'b0;
              state_q <= zero_pass_q ? s_ecmd1 : s_end;
            end else begin
              addr_q <= addr_q + pfep_pkg::addr_step;
              state_q <= s_pcmd;
            end
          end else if (ppulse_q >= pfep_pkg::max_pulses) begin
            fail_lane <= ~(lane_ok_q | match);
            state_q <= s_idle;
          end else begin
            lane_ok_q <= lane_ok_q | match;
            state_q <= s_pcmd;
          end
        end
        s_ecmd1: state_q <= s_ecmd2;
        s_ecmd2: begin
          epulse_q <= epulse_q + 16'h0001;
          state_q <= s_epulse;
        end
        s_epulse: if (tmr_done) state_q <= s_ever;
        s_ever: state_q <= s_eset;
        s_eset: if (tmr_done) state_q <= s_echk;
        s_echk: begin
          if ((lane_ok_q | match) == 2'b11) begin
            lane_ok_q <= 2'b00;
            if (addr_q >= last_addr) begin
              state_q <= s_end;
            end else begin
              addr_q <= addr_q + pfep_pkg::addr_step;
              state_q <= s_ever;
            end
          end else if (epulse_q >= pfep_pkg::max_erase_pulses) begin
            fail_lane <= ~(lane_ok_q | match);
            state_q <= s_idle;
          end else begin
            lane_ok_q <= lane_ok_q | match;
            state_q <= s_ecmd1;
          end
        end
        s_end: begin
          done <= 1'b1;
          state_q <= s_idle;
        end
        default: state_q <= s_idle;
      endcase
    end
  end
  assign busy = state_q != s_idle;
  assign prog_req = state_q == s_pcmd && !zero_pass_q;
  assign prog_addr = addr_q;
  // byte mode is not built: word mode serves both devices at once
  //////////////////////////////////////////////////////////////////////
  a_erase_twice: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_ecmd1 |=> state_q == s_ecmd2 ##1 state_q == s_epulse)
    else $error("erase command not doubled");
  a_verify_after: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_epulse && tmr_done |=> state_q == s_ever)
    else $error("no verify after erase");
  a_addr_step: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_echk && (lane_ok_q | match) == 2'b11 &&
    addr_q < last_addr |=> addr_q == $past(addr_q) + 16'h0002)
    else $error("bad address step");
  a_addr_hold: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_echk && (lane_ok_q | match) != 2'b11 |=>
    $stable(addr_q)) else $error("address moved on retry");
  a_mask_lane: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_ever && lane_ok_q[0] |-> cmd_word[7:0] == 8'hff)
    else $error("verified lane not masked");
  a_setup_wait: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_pver |=> state_q == s_pset [*8])
    else $error("verify read too early");
  a_retry_prog: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_pchk && (lane_ok_q | match) != 2'b11 &&
    ppulse_q < 8'h19 |=> state_q == s_pcmd)
    else $error("program loop broken");
  a_fail_flag: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_pchk && (lane_ok_q | match) != 2'b11 &&
    ppulse_q >= 8'h19 |=> fail_lane != 2'b00)
    else $error("failure not flagged");
  a_setup_min: assert property (@(posedge mclk) disable iff (reset)
    state_q inside {s_pchk, s_echk} |-> wait_q >= pfep_pkg::vsetup_cyc)
    else $error("verify read before set-up time");
  a_pulse_min: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_pver |-> wait_q >= pfep_pkg::prog_cyc - 32'h0000_0001)
    else $error("program pulse too short");
  a_data_masked: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_ppulse && $past(state_q) == s_pdata && lane_ok_q[0] |->
    fbus.wdata[7:0] == pfep_pkg::cmd_reset)
    else $error("data reached a finished lane");
  a_fail_clear: assert property (@(posedge mclk) disable iff (reset)
    busy |-> fail_lane == 2'b00)
    else $error("stale failure while busy");
  a_zero_first: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_ecmd1 && $past(state_q) == s_pchk |-> $past(zero_pass_q))
    else $error("erase without zero pass");
  a_bus_excl: assert property (@(posedge mclk) disable iff (reset)
    !(fbus.we && fbus.oe))
    else $error("write and read together");
  a_done_end: assert property (@(posedge mclk) disable iff (reset)
    $rose(done) |-> $past(state_q) == s_end)
    else $error("done without finishing");
  a_erase_judge: assert property (@(posedge mclk) disable iff (reset)
    state_q == s_echk && fdata_in[15:8] != pfep_pkg::data_erased |->
    !match[1])
    else $error("high lane judged erased");
  c_erase_done: cover property (@(posedge mclk) disable iff (reset)
    state_q == s_echk ##1 state_q == s_end);
  c_partial: cover property (@(posedge mclk) disable iff (reset)
    state_q == s_echk && (lane_ok_q | match) == 2'b01);
  c_prog_retry: cover property (@(posedge mclk) disable iff (reset)
    state_q == s_pchk ##1 state_q == s_pcmd ##1 state_q == s_pdata);
  c_zero_to_erase: cover property (@(posedge mclk) disable iff (reset)
    state_q == s_pchk ##1 state_q == s_ecmd1);
  c_lane_fail: cover property (@(posedge mclk) disable iff (reset)
    state_q == s_pchk ##1 fail_lane != 2'b00);
endmodule // pfep_seq

// ==== testbench/pfep_flash_model.sv ====
`timescale 1ns/1ps
module pfep_flash_model (
  input wire logic mclk, // Clock
  input wire logic reset, // Async reset
  input wire pfep_pkg::pfep_bus_type fbus, // Bus from sequencer
  output logic [15:0] fdata, // Read data
  input wire logic slow, // High lane needs three pulses
  input wire logic stuck, // High lane never programs
  input wire logic [2:0] peek_addr, // Array word to show
  output logic [15:0] peek, // Array word shown
  output logic [15:0] pulses, // Program pulses, a byte per lane
  output logic [1:0] viol, // Short pulse, early read
  output logic [7:0] erases // Erase pulses begun
);
  typedef enum logic [2:0] {rd_s, psu_s, pgm_s, ver_s, er1_s, ers_s}
    pfep_mode_type;
  logic [7:0] mem_q [2][8];
  pfep_mode_type mode_q [2];
  logic [31:0] cyc_q;
  logic [31:0] t0_q [2];
  logic [1:0] acc_q [2];
  logic [7:0] pd_q [2];
  logic [1:0][7:0] wb;
  logic [15:0] rd, last_q;
  logic oe_q;
  assign wb = fbus.wdata;
  assign rd = {mem_q[1][fbus.addr[3:1]], mem_q[0][fbus.addr[3:1]]};
  assign peek = {mem_q[1][peek_addr], mem_q[0][peek_addr]};
  // Released bus shows the inverse so a stale read cannot pass
  assign fdata = (fbus.oe || oe_q) ? rd : ~last_q;
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cyc_q <= '0;
      oe_q <= 1'b0;
      last_q <= '0;
      viol <= '0;
      erases <= '0;
      pulses <= '0;
      for (int l = 0; l < 2; l++) begin
        mode_q[l] <= rd_s;
        acc_q[l] <= '0;
        for (int a = 0; a < 8; a++) mem_q[l][a] <= 8'hff;
      end
    end else begin
      cyc_q <= cyc_q + 32'h1;
      oe_q <= fbus.oe;
      if (fbus.oe) last_q <= rd;
      for (int l = 0; l < 2; l++) begin
        if (oe_q && !fbus.oe && mode_q[l] == ver_s &&
            cyc_q - t0_q[l] < pfep_pkg::vsetup_cyc) viol[1] <= 1'b1;
        if (fbus.we) begin
          t0_q[l] <= cyc_q;
          if (mode_q[l] == psu_s) begin
            pd_q[l] <= wb[l];
            mode_q[l] <= pgm_s;
          end else if (mode_q[l] == pgm_s &&
              wb[l] == pfep_pkg::cmd_pverify) begin
            if (cyc_q - t0_q[l] < pfep_pkg::prog_cyc) viol[0] <= 1'b1;
            pulses[8*l +: 8] <= pulses[8*l +: 8] + 8'h1;
            mode_q[l] <= ver_s;
            if (!(l == 1 && stuck) && (acc_q[l] == 2'h2 ||
                !(l == 1 && slow) || pd_q[l] == 8'hff)) begin
              mem_q[l][fbus.addr[3:1]] <= mem_q[l][fbus.addr[3:1]] & pd_q[l];
              acc_q[l] <= 2'h0;
            end else acc_q[l] <= acc_q[l] + 2'h1;
          end else if (mode_q[l] == ers_s &&
              wb[l] == pfep_pkg::cmd_everify) begin
            if (cyc_q - t0_q[l] < pfep_pkg::erase_cyc) viol[0] <= 1'b1;
            else for (int a = 0; a < 8; a++) mem_q[l][a] <= 8'hff;
            mode_q[l] <= ver_s;
          end else if (wb[l] == pfep_pkg::cmd_erase) begin
            mode_q[l] <= (mode_q[l] == er1_s) ? ers_s : er1_s;
            if (mode_q[l] == er1_s && l == 0) erases <= erases + 8'h1;
          end else begin
            mode_q[l] <= wb[l] == pfep_pkg::cmd_program ? psu_s :
              (wb[l] == pfep_pkg::cmd_reset ? rd_s : ver_s);
          end
        end
      end
    end
  end
endmodule // pfep_flash_model

// ==== testbench/tb_parallel_flash_erase_program.sv ====
`timescale 1ns/1ps
module tb_parallel_flash_erase_program;
  logic mclk = 1'b0, reset = 1'b1, start = 1'b0, op_erase = 1'b0;
  logic slow = 1'b0, stuck = 1'b0, prog_req, busy, done;
  logic [15:0] last_addr = 16'h0006, prog_data, prog_addr, fdata_in;
  logic [15:0] pulses, peek;
  logic [1:0] fail_lane, viol;
  logic [2:0] peek_addr = 3'h0;
  logic [7:0] erases;
  logic [15:0] reqs = 16'h0000, ep;
  logic [31:0] lfsr = 32'h5238;
  logic [15:0] img [8];
  pfep_pkg::pfep_bus_type fbus;
  int miscompares = 0, total_checks = 0;
  always #25 mclk = ~mclk;
  assign prog_data = img[prog_addr[3:1]];
  // Counted off the edge so the combinational request has settled
  always @(negedge mclk) if (prog_req === 1'b1) reqs <= reqs + 16'h0001;
  pfep_seq i_pfep_seq (.mclk(mclk), .reset(reset), .start(start),
    .op_erase(op_erase), .last_addr(last_addr), .prog_data(prog_data),
    .prog_req(prog_req), .prog_addr(prog_addr), .fbus(fbus),
    .fdata_in(fdata_in), .busy(busy), .done(done), .fail_lane(fail_lane));
  pfep_flash_model i_pfep_flash_model (.mclk(mclk), .reset(reset),
    .fbus(fbus), .fdata(fdata_in), .slow(slow), .stuck(stuck),
    .peek_addr(peek_addr), .peek(peek), .pulses(pulses), .viol(viol),
    .erases(erases));
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [15:0] exp_pulses(input logic s, input int n);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = '0;
    lo = '0;
    for (int a = 0; a < n; a++) begin
      lo++;
      hi += (s && img[a][15:8] !== 8'hff) ? 8'h3 : 8'h1;
    end
    return {hi, lo};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic new_image;
    for (int a = 0; a < 8; a++) begin
      lfsr = lfsr_next(lfsr);
      img[a] = lfsr[15:0];
    end
  endtask
  task automatic do_reset;
    reset = 1'b1;
    repeat (16) @(posedge mclk);
    #2;
    reset = 1'b0;
  endtask
  // Second start mid-run must be ignored while busy
  task automatic run(input logic erase, input int lim);
    int i;
    @(posedge mclk);
    #2;
    op_erase = erase;
    reqs = 16'h0000;
    start = 1'b1;
    @(posedge mclk);
    #2;
    start = 1'b0;
    for (i = 0; i < lim && busy === 1'b1 && erases == 8'h0; i++) begin
      @(posedge mclk);
      #2;
      start = (i == 40);
    end
    if (i >= lim) begin
      miscompares++;
      tally_and_finish();
    end
  endtask
  task automatic look(input int a, input logic [15:0] exp);
    peek_addr = a[2:0];
    #1;
    check(peek, exp);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    new_image();
    img[1] = 16'hffff;
    img[3] = 16'h00ff;
    slow = 1'b1;
    do_reset();
    run(1'b0, 20000);
    check({15'h0, done}, 16'h1);
    check({14'h0, fail_lane}, 16'h0);
    check({14'h0, viol}, 16'h0);
    ep = exp_pulses(1'b1, 4);
    check(pulses, ep);
    check(reqs, {8'h00, ep[15:8]});
    for (int a = 0; a < 4; a++) look(a, img[a]);
    new_image();
    img[0][15:8] = 8'h00;
    slow = 1'b0;
    stuck = 1'b1;
    do_reset();
    run(1'b0, 20000);
    check({14'h0, fail_lane}, 16'h2);
    check({15'h0, done}, 16'h0);
    check(pulses, {pfep_pkg::max_pulses, 8'h01});
    stuck = 1'b0;
    last_addr = 16'h0002;
    do_reset();
    run(1'b1, 3000);
    check({8'h0, erases}, 16'h1);
    check({15'h0, busy}, 16'h1);
    check({14'h0, viol}, 16'h0);
    check(reqs, 16'h0000);
    for (int a = 0; a < 2; a++) look(a, 16'h0000);
    tally_and_finish();
  end
endmodule // tb_parallel_flash_erase_program
